// ==== shared/flash_pp_pkg.sv ====
// Constants, codes and types for the parallel-mode flash programming host.
// Assumes a 40 MHz system clock and one byte-wide flash on multiplexed pins.
package flash_pp_pkg;

    // ==========================================================
    // Widths and clock
    // ==========================================================
    localparam int ADDR_W = 22;          // Full byte address, row plus column
    localparam int PIN_ADDR_W = 11;      // Multiplexed address pins
    localparam int CLK_PERIOD_NS = 25;   // sys_clk period

    // ==========================================================
    // Timing figures and derived cycle counts
    // ==========================================================
    localparam int WE_LOW_MIN_NS = 5;    // Shorter strobes are ignored by the flash
    localparam int WE_LOW_CALC = (WE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] WE_LOW_CYC = 2'((WE_LOW_CALC < 1) ? 1 : WE_LOW_CALC);
    localparam logic [1:0] READ_WAIT_CYC = 2'h2;  // Output enable low time for a read
    localparam int SETTLE_US = 1;        // Whole bus valid this long after completion
    localparam logic [11:0] SETTLE_CYC =
        12'((SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int PROG_MAX_US = 20;     // Longest byte program
    localparam logic [11:0] PROG_MAX_CYC = 12'((PROG_MAX_US * 1000) / CLK_PERIOD_NS);

    // ==========================================================
    // Command sequence addresses and data
    // ==========================================================
    localparam logic [21:0] UNLOCK_ADDR_A = 22'h005555;
    localparam logic [21:0] UNLOCK_ADDR_B = 22'h002AAA;
    localparam logic [21:0] EXIT_ADDR = 22'h000000;
    localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
    localparam logic [7:0] CODE_PROGRAM = 8'hA0;
    localparam logic [7:0] CODE_ERASE = 8'h80;
    localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
    localparam logic [7:0] CODE_ID_EXIT = 8'hF0;
    localparam logic [7:0] CODE_SECTOR = 8'h30;
    localparam logic [7:0] CODE_BLOCK = 8'h50;
    localparam logic [7:0] CODE_CHIP = 8'h10;

    // ==========================================================
    // Operations offered to the user
    // ==========================================================
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_SECTOR_ERASE = 3'h2,
        OP_BLOCK_ERASE = 3'h3,
        OP_CHIP_ERASE = 3'h4,
        OP_ID_ENTRY = 3'h5,
        OP_ID_EXIT = 3'h6
    } op_type;

endpackage : flash_pp_pkg

// ==== verilog/pp_bus_cycle.sv ====
// One bus cycle on the multiplexed flash pins: row, column, then strobe.
// Assumes the caller starts a cycle only while none is running.
`timescale 1ns/1ps
module pp_bus_cycle (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic is_write,
    input wire logic [21:0] addr,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata,
    output logic [10:0] pin_addr,
    output logic rc_n,
    output logic oe_n,
    output logic we_n,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe
);
    import flash_pp_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [2:0] {
        C_IDLE = 3'h0,
        C_ROWL = 3'h1,
        C_COL = 3'h2,
        C_COLH = 3'h3,
        C_STRB = 3'h4,
        C_END = 3'h5
    } cyc_state_type;

    typedef struct packed {
        cyc_state_type state;
        logic [21:0] addr;   // Latched address
        logic write;         // Cycle kind
        logic [1:0] cnt;     // Strobe length counter
        logic [7:0] rdata;
        logic done;
        logic [10:0] pa;
        logic rc_n;
        logic oe_n;
        logic we_n;
        logic [7:0] dq_out;
        logic dq_oe;
    } cyc_reg_type;

    cyc_reg_type r_reg, r_next;
    logic [1:0] limit;       // Strobe length of this cycle

    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        limit = r_reg.write ? WE_LOW_CYC : READ_WAIT_CYC;
        case (r_reg.state)
            C_IDLE: begin
                if (start) begin
                    r_next.addr = addr;
                    r_next.write = is_write;
                    r_next.dq_out = wdata;
                    r_next.pa = addr[10:0];
                    r_next.rc_n = 1'b1;
                    r_next.state = C_ROWL;
                end
            end
            C_ROWL: begin
                // Falling select latches the row half
                r_next.rc_n = 1'b0;
                r_next.state = C_COL;
            end
            C_COL: begin
                r_next.pa = r_reg.addr[21:11];
                r_next.state = C_COLH;
            end
            C_COLH: begin
                // Rising select latches the column half; data set up early
                r_next.rc_n = 1'b1;
                r_next.dq_oe = r_reg.write;
                r_next.cnt = 2'h0;
                r_next.state = C_STRB;
            end
            C_STRB: begin
                // Output enable stays high through writes
                if (r_reg.write) begin
                    r_next.we_n = 1'b0;  // Never shorter than one period
                end else begin
                    r_next.oe_n = 1'b0;
                end
                r_next.cnt = r_reg.cnt + 2'h1;
                if (r_reg.cnt + 2'h1 >= limit) begin
                    r_next.state = C_END;
                end
            end
            C_END: begin
                // Rising write strobe hands the byte to the flash
                r_next.rdata = r_reg.write ? r_reg.rdata : dq_in;
                r_next.we_n = 1'b1;
                r_next.oe_n = 1'b1;
                r_next.done = 1'b1;
                r_next.state = C_IDLE;
            end
            default: begin
                r_next.state = C_IDLE;
            end
        endcase
        // Data released only once the strobe is back high
        if (r_reg.state == C_IDLE) begin
            r_next.dq_oe = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '{state: C_IDLE, addr: 22'h000000, write: 1'b0, cnt: 2'h0,
                       rdata: 8'h00, done: 1'b0, pa: 11'h000, rc_n: 1'b1,
                       oe_n: 1'b1, we_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign done = r_reg.done;
    assign rdata = r_reg.rdata;
    assign pin_addr = r_reg.pa;
    assign rc_n = r_reg.rc_n;
    assign oe_n = r_reg.oe_n;
    assign we_n = r_reg.we_n;
    assign dq_out = r_reg.dq_out;
    assign dq_oe = r_reg.dq_oe;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_col_then_strobe;
        ##2 $rose(rc_n) ##1 (!we_n || !oe_n);
    endsequence

    chk_cycle_order: assert property ($fell(rc_n) |-> s_col_then_strobe)
        else $error("address phases out of order");
    chk_write_inhibit: assert property (!we_n |-> oe_n)
        else $error("output enable low during a write strobe");
    chk_data_held: assert property ($rose(we_n) |-> dq_oe && $stable(dq_out))
        else $error("data not held at rising write strobe");
    chk_row_stable: assert property ($fell(rc_n) |-> $stable(pin_addr))
        else $error("address moved at row latch");
endmodule : pp_bus_cycle

// ==== verilog/flash_pp_host.sv ====
// Host sequencer that programs, erases and identifies a parallel-mode flash.
// Assumes one flash on the pins and a user that waits for cmd_ready.
//
// How it works
// - Final read waits one microsecond after completion.
// - Poll only inside the valid address range.
// - Completion accepted after two matching rereads.
// - Program sends AA, 55, A0, then byte.
// - Erase sends six-cycle sequence with code.
// - Sequence cycles issued with two idle clocks between them.
// - Low pin count range, not used here.
`timescale 1ns/1ps
module flash_pp_host (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire flash_pp_pkg::op_type cmd_op,
    input wire logic [21:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic cmd_done,
    output logic cmd_err,
    output logic [7:0] cmd_rdata,
    output logic flash_rst_n,
    output logic [10:0] flash_addr,
    output logic flash_rc_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    input wire logic [7:0] flash_dq_in,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe
);
    import flash_pp_pkg::*;

    // ==========================================================
    // Sequence tables
    // ==========================================================
    // Number of write cycles in each command
    function automatic logic [2:0] seq_len(input op_type op);
        case (op)
            OP_PROGRAM: seq_len = 3'h4;
            OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: seq_len = 3'h6;
            OP_ID_ENTRY: seq_len = 3'h3;
            OP_ID_EXIT: seq_len = 3'h1;
            default: seq_len = 3'h0;
        endcase
    endfunction : seq_len

    // Address and data of one write cycle; unused upper bits stay zero
    function automatic logic [29:0] seq_step(input op_type op, input logic [2:0] idx,
                                             input logic [21:0] a, input logic [7:0] d);
        logic [7:0] code;
        code = CODE_ERASE;
        if (op == OP_PROGRAM) code = CODE_PROGRAM;
        if (op == OP_ID_ENTRY) code = CODE_ID_ENTRY;
        seq_step = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
        if (op == OP_ID_EXIT) begin
            seq_step = {EXIT_ADDR, CODE_ID_EXIT};  // Single-cycle exit
        end else begin
            case (idx)
                3'h1: seq_step = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
                3'h2: seq_step = {UNLOCK_ADDR_A, code};
                3'h3: seq_step = (op == OP_PROGRAM) ? {a, d}
                                                   : {UNLOCK_ADDR_A, UNLOCK_DATA_A};
                3'h4: seq_step = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
                3'h5: begin
                    case (op)
                        OP_SECTOR_ERASE: seq_step = {a, CODE_SECTOR};
                        OP_BLOCK_ERASE: seq_step = {a, CODE_BLOCK};
                        default: seq_step = {UNLOCK_ADDR_A, CODE_CHIP};
                    endcase
                end
                default: seq_step = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
            endcase
        end
    endfunction : seq_step

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_SEND = 4'h1,
        S_WAITW = 4'h2,
        S_POLL = 4'h3,
        S_WAITR = 4'h4,
        S_SETTLE = 4'h5,
        S_FINAL = 4'h6,
        S_WAITF = 4'h7,
        S_DONE = 4'h8
    } seq_state_type;

    typedef struct packed {
        seq_state_type state;
        op_type op;
        logic [21:0] addr;    // Target address
        logic [7:0] data;     // Byte to program
        logic [2:0] idx;      // Cycle within the sequence
        logic [1:0] confirms; // Matching rereads so far
        logic [11:0] timer;   // Poll and settle timer
        logic [7:0] rdata;
        logic err;
        logic frst_n;
    } main_reg_type;

    main_reg_type r_reg, r_next;
    logic [29:0] step;
    logic [21:0] poll_addr;
    logic cyc_start, cyc_write, cyc_done;
    logic [21:0] cyc_addr;
    logic [7:0] cyc_rdata;
    logic poll_ok;

    // Cycle requests and addresses
    always_comb begin
        step = seq_step(r_reg.op, r_reg.idx, r_reg.addr, r_reg.data);
        // Chip erase polls a fixed in-range location
        poll_addr = (r_reg.op == OP_CHIP_ERASE) ? UNLOCK_ADDR_A : r_reg.addr;
        cyc_start = (r_reg.state == S_SEND) || (r_reg.state == S_POLL) ||
                    (r_reg.state == S_FINAL);
        cyc_write = (r_reg.state == S_SEND);
        if (r_reg.state == S_SEND) begin
            cyc_addr = step[29:8];
        end else if (r_reg.state == S_POLL) begin
            cyc_addr = poll_addr;
        end else begin
            cyc_addr = r_reg.addr;
        end
        // Program polls for the true bit, erase for one
        poll_ok = (r_reg.op == OP_PROGRAM) ? (cyc_rdata[7] == r_reg.data[7])
                                           : cyc_rdata[7];
    end

    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.frst_n = 1'b1;  // Flash leaves reset one edge after ours
        if (r_reg.state == S_POLL || r_reg.state == S_WAITR ||
            r_reg.state == S_SETTLE) begin
            r_next.timer = (r_reg.timer == 12'hFFF) ? r_reg.timer : r_reg.timer + 12'h001;
        end
        case (r_reg.state)
            S_IDLE: begin
                // Only accepted between operations
                if (cmd_valid && r_reg.frst_n) begin
                    r_next.op = cmd_op;
                    r_next.addr = cmd_addr;
                    r_next.data = cmd_data;
                    r_next.idx = 3'h0;
                    r_next.err = 1'b0;
                    r_next.state = (cmd_op == OP_READ) ? S_FINAL : S_SEND;
                end
            end
            S_SEND: begin
                r_next.state = S_WAITW;
            end
            S_WAITW: begin
                if (cyc_done) begin
                    if (r_reg.idx == seq_len(r_reg.op) - 3'h1) begin
                        // Status valid right after the last strobe
                        r_next.timer = 12'h000;
                        r_next.confirms = 2'h0;
                        r_next.state = (r_reg.op == OP_ID_ENTRY || r_reg.op == OP_ID_EXIT)
                                       ? S_DONE : S_POLL;
                    end else begin
                        r_next.idx = r_reg.idx + 3'h1;  // Two idle clocks before the next cycle
                        r_next.state = S_SEND;
                    end
                end
            end
            S_POLL: begin
                r_next.state = S_WAITR;
            end
            S_WAITR: begin
                if (cyc_done) begin
                    if (poll_ok && r_reg.confirms == 2'h2) begin
                        r_next.timer = 12'h000;
                        r_next.state = (r_reg.op == OP_PROGRAM) ? S_SETTLE : S_DONE;
                    end else if (poll_ok) begin
                        // A racing read may mislead; reread twice
                        r_next.confirms = r_reg.confirms + 2'h1;
                        r_next.state = S_POLL;
                    end else if (r_reg.op == OP_PROGRAM && r_reg.timer >= PROG_MAX_CYC) begin
                        r_next.err = 1'b1;  // Overran the program time
                        r_next.state = S_DONE;
                    end else begin
                        r_next.confirms = 2'h0;
                        r_next.state = S_POLL;
                    end
                end
            end
            S_SETTLE: begin
                // Other data bits may lag the poll bit
                if (r_reg.timer >= SETTLE_CYC - 12'h001) begin
                    r_next.state = S_FINAL;
                end
            end
            S_FINAL: begin
                r_next.state = S_WAITF;
            end
            S_WAITF: begin
                if (cyc_done) begin
                    r_next.rdata = cyc_rdata;
                    r_next.state = S_DONE;
                end
            end
            S_DONE: begin
                r_next.state = S_IDLE;
            end
            default: begin
                r_next.state = S_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '{state: S_IDLE, op: OP_READ, addr: 22'h000000, data: 8'h00,
                       idx: 3'h0, confirms: 2'h0, timer: 12'h000, rdata: 8'h00,
                       err: 1'b0, frst_n: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign cmd_ready = (r_reg.state == S_IDLE) && r_reg.frst_n;
    assign cmd_done = (r_reg.state == S_DONE);
    assign cmd_err = r_reg.err;
    assign cmd_rdata = r_reg.rdata;
    assign flash_rst_n = r_reg.frst_n;

    // ==========================================================
    // Pin cycle engine
    // ==========================================================
    // Row on falling select, column on rising, data at rising strobe
    pp_bus_cycle u_cycle (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(step[7:0]),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .pin_addr(flash_addr),
        .rc_n(flash_rc_n),
        .oe_n(flash_oe_n),
        .we_n(flash_we_n),
        .dq_in(flash_dq_in),
        .dq_out(flash_dq_out),
        .dq_oe(flash_dq_oe)
    );

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_unlock_first: assert property ((r_reg.state == S_SEND && r_reg.idx == 3'h0 &&
        r_reg.op != OP_ID_EXIT) |-> (cyc_addr == UNLOCK_ADDR_A && step[7:0] == 8'hAA))
        else $error("sequence does not open with the unlock write");
    chk_seq_count: assert property ((r_reg.state == S_POLL &&
        $past(r_reg.state) == S_WAITW) |->
        $past(r_reg.idx) == ((r_reg.op == OP_PROGRAM) ? 3'h3 : 3'h5))
        else $error("wrong number of command cycles before polling");
    chk_confirm_twice: assert property ((r_reg.state == S_SETTLE &&
        $past(r_reg.state) == S_WAITR) |-> $past(r_reg.confirms) == 2'h2)
        else $error("completion accepted without two rereads");
    chk_settle_time: assert property ((r_reg.state == S_FINAL &&
        r_reg.op == OP_PROGRAM) |-> $past(r_reg.timer) >= SETTLE_CYC - 12'h001)
        else $error("final read too soon after completion");
    chk_poll_addr: assert property ((r_reg.state == S_POLL &&
        r_reg.op == OP_CHIP_ERASE) |-> cyc_addr == UNLOCK_ADDR_A)
        else $error("poll address outside the chosen location");
    chk_busy_refuse: assert property ((r_reg.state != S_IDLE) |-> !cmd_ready ##1
        ($stable(r_reg.op) && $stable(r_reg.addr)))
        else $error("command taken during an operation");
    chk_rst_quiet: assert property (!flash_rst_n |-> flash_we_n && flash_oe_n)
        else $error("strobe while flash held in reset");
    chk_prog_result: assert property ((r_reg.state == S_SETTLE &&
        $past(r_reg.state) == S_WAITR) |-> $past(cyc_rdata[7]) == r_reg.data[7])
        else $error("program completion on wrong poll bit");
endmodule : flash_pp_host

// ==== test/flash_dev_model.sv ====
// Behavioural parallel-mode flash that stands on the host's pins.
// Assumes sys_clk paces internal operations; pins are sampled on their own edges.
`timescale 1ns/1ps
module flash_dev_model #(
    parameter logic [7:0] MAKER_ID = 8'h1E, // Arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h2D, // Arbitrary value
    parameter int PROG_CYC = 100,
    parameter int ERASE_CYC = 300
) (
    input wire logic sys_clk,
    input wire logic hang,
    input wire logic rst_n,
    input wire logic [10:0] addr_pins,
    input wire logic rc_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_host,
    output logic [7:0] dq_dev
);
    // ==========================================================
    // Array and operation state
    // ==========================================================
    logic [7:0] mem [int]; // Missing bytes read as erased
    logic [21:0] a = 22'h0;
    logic [7:0] pd = 8'h0, last = 8'h0;
    logic erasing = 1'b0, id_mode = 1'b0, tog = 1'b0;
    int step = 0, busy = 0, settle = 0;
    realtime t_fall = 0.0;

    task automatic write_cmd(input logic [21:0] wa, input logic [7:0] d);
        logic [15:0] lo;
        int n;
        lo = wa[15:0]; // Upper field ignored
        n = (d == 8'h30) ? 4096 : 65536;
        if (d == 8'hF0 && step < 3) begin // Single or three-cycle exit
            id_mode = 1'b0;
            step = 0;
        end else case (step)
            0: step = (lo == 16'h5555 && d == 8'hAA) ? 1 : 0;
            1: step = (lo == 16'h2AAA && d == 8'h55) ? 2 : 0;
            2: begin
                id_mode = id_mode | (lo == 16'h5555 && d == 8'h90);
                step = (lo != 16'h5555) ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
            end
            3: begin // Programming only clears bits
                mem[wa] = (mem.exists(wa) ? mem[wa] : 8'hFF) & d;
                pd = d;
                erasing = 1'b0;
                busy = hang ? 2000 : PROG_CYC;
                step = 0;
            end
            4: step = (lo == 16'h5555 && d == 8'hAA) ? 5 : 0;
            5: step = (lo == 16'h2AAA && d == 8'h55) ? 6 : 0;
            default: begin
                if (d == 8'h10 && lo == 16'h5555) mem.delete();
                if (d == 8'h30 || d == 8'h50)
                    for (int i = 0; i < n; i++) mem.delete(int'(wa) & ~(n - 1) | i);
                erasing = (d == 8'h10 && lo == 16'h5555) || d == 8'h30 || d == 8'h50;
                busy = erasing ? ERASE_CYC : 0;
                step = 0;
            end
        endcase
    endtask : write_cmd

    // ==========================================================
    // Pin capture; all but the write strobe fall time is ignored while held in reset
    // ==========================================================
    always @(negedge rc_n) if (rst_n) a[10:0] = addr_pins;
    always @(posedge rc_n) if (rst_n) a[21:11] = addr_pins;
    always @(negedge we_n) t_fall = $realtime;
    // Glitches, inhibit and writes during an operation are dropped
    always @(posedge we_n) if (rst_n && oe_n && busy == 0 && $realtime - t_fall >= 5.0)
        write_cmd(a, dq_host);

    // Internal timer, then after a program a settling window for bits 6..0
    always @(posedge sys_clk) begin
        if (busy > 0) begin
            busy = busy - 1;
            if (busy == 0 && !erasing) settle = 40;
        end else if (settle > 0) settle = settle - 1;
    end

    always @(negedge oe_n) if (rst_n) begin
        if (busy > 0) begin
            tog = ~tog;
            last = erasing ? {1'b0, tog, 6'h0} : {~pd[7], tog, ~pd[5:0]};
        end else if (id_mode) last = a[0] ? DEVICE_ID : MAKER_ID;
        else begin
            last = mem.exists(a) ? mem[a] : 8'hFF;
            if (settle > 0) last[6:0] = ~last[6:0];
        end
    end
    // A released bus never shows the last value
    assign dq_dev = (rst_n && !oe_n) ? last : ~last;
endmodule : flash_dev_model

// ==== test/tb.sv ====
// Self-checking bench for the parallel-mode flash host.
// Assumes the behavioural flash model on the pins and a 40 MHz clock.
`timescale 1ns/1ps
module tb;
    import flash_pp_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, hang = 1'b0;
    op_type cmd_op = OP_READ;
    logic [21:0] cmd_addr = 22'h0;
    logic [7:0] cmd_data = 8'h0, cmd_rdata, flash_dq_in, flash_dq_out;
    logic cmd_ready, cmd_done, cmd_err, flash_rst_n, flash_rc_n, flash_oe_n, flash_we_n;
    logic flash_dq_oe;
    logic [10:0] flash_addr;
    int n_mismatch = 0, total_checks = 0, cycles = 0;

    flash_pp_host dut (.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_rdata(cmd_rdata),
        .flash_rst_n(flash_rst_n), .flash_addr(flash_addr), .flash_rc_n(flash_rc_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_in(flash_dq_in),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
    flash_dev_model flash (.sys_clk(sys_clk), .hang(hang), .rst_n(flash_rst_n),
        .addr_pins(flash_addr), .rc_n(flash_rc_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
        .dq_host(flash_dq_oe ? flash_dq_out : flash_dq_in), .dq_dev(flash_dq_in));

    initial forever #12.5 sys_clk = ~sys_clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    // Hang guard: far above the few thousand cycles the tests need
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One command: present, hand over, then wait for the done pulse
    task automatic run(input op_type op, input logic [21:0] ad, input logic [7:0] d);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1) @(posedge sys_clk) #1;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_data <= d;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        #1;
        check("ready while busy", {7'h0, cmd_ready}, 8'h00);
        while (cmd_done !== 1'b1 && k < 3000) begin
            @(posedge sys_clk) #1;
            k++;
        end
        check("done seen", {7'h0, cmd_done}, 8'h01);
    endtask : run

    task automatic t_program();
        run(OP_PROGRAM, 22'h012345, 8'h3C);
        check("settled final read", cmd_rdata, 8'h3C);
        check("program err", {7'h0, cmd_err}, 8'h00);
        run(OP_READ, 22'h012345, 8'h00);
        check("array read", cmd_rdata, 8'h3C);
        $display("test program done");
    endtask : t_program

    // Sector, block, chip: a late finish would drop the next program
    task automatic t_erase();
        for (int i = 0; i < 3; i++) begin
            run(OP_PROGRAM, 22'h012345, 8'h00);
            check("program after erase", cmd_rdata, 8'h00);
            run(op_type'(3'(2 + i)), 22'h012345, 8'h00);
            run(OP_READ, 22'h012345, 8'h00);
            check("erased byte", cmd_rdata, 8'hFF);
        end
        $display("test erase done");
    endtask : t_erase

    task automatic t_ident();
        run(OP_ID_ENTRY, 22'h0, 8'h00);
        run(OP_READ, 22'h0, 8'h00);
        check("maker code", cmd_rdata, flash.MAKER_ID);
        run(OP_READ, 22'h1, 8'h00);
        check("device code", cmd_rdata, flash.DEVICE_ID);
        run(OP_ID_EXIT, 22'h0, 8'h00);
        run(OP_READ, 22'h1, 8'h00);
        check("array after exit", cmd_rdata, 8'hFF);
        $display("test ident done");
    endtask : t_ident

    task automatic t_overrun();
        @(posedge sys_clk) hang <= 1'b1;
        run(OP_PROGRAM, 22'h000100, 8'h5A);
        check("overrun flag", {7'h0, cmd_err}, 8'h01);
        $display("test overrun done");
    endtask : t_overrun

    initial begin
        repeat (6) @(posedge sys_clk);
        check("flash reset pin", {7'h0, flash_rst_n}, 8'h00);
        check("strobes idle", {6'h0, flash_we_n, flash_oe_n}, 8'h03);
        resetn <= 1'b1;
        t_program();
        t_erase();
        t_ident();
        t_overrun();
        end_sim();
    end
endmodule : tb
